//--- logic/addr_shift.sv
/*
  Barrel shifter: picks a 16-bit window of the byte address.
  Assumes the shift amount is at most 13; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module addr_shift (
  // Address in
  input  wire logic [31:0] byte_address,
  input  wire logic [3:0]  shift,
  // Window out
  output logic      [15:0] slice
);

  logic [31:0] shifted;

  assign shifted = byte_address >> shift;
  assign slice   = shifted[15:0];

endmodule
`default_nettype wire

//--- logic/sdram_addr_pkg.sv
/*
  Shared constants and types for the SDRAM row/column address multiplexer.
  Assumes a single clock domain; all widths are fixed.
*/
`default_nettype none
package sdram_addr_pkg;

  // Device generation served by the multiplexer
  typedef enum logic [1:0] {
    GEN_EARLY  = 2'b00,
    GEN_SECOND = 2'b01,
    GEN_THIRD  = 2'b10
  } gen_e;

  // Which address phase the pins currently show
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ROW  = 2'b01,
    PH_COL  = 2'b10
  } phase_e;

  // Pin and logical-slot geometry
  localparam int unsigned PIN_W       = 23;
  localparam int unsigned LOGICAL_W   = 20;
  localparam int unsigned SLICE_W     = 16;
  localparam int unsigned K_PRECHARGE = 10;
  localparam int unsigned K_INDICATOR = 16;
  localparam int unsigned K_EARLY_TOP = 14;

  // Lowest external pin used by each port layout
  localparam logic [1:0] BASE_EARLY  = 2'h2;
  localparam logic [1:0] BASE_WIDE   = 2'h3;
  localparam logic [1:0] BASE_NARROW = 2'h1;

  // Log2 of bus bytes: 8, 16, 32, 64 bit
  localparam logic [1:0] BUS_8  = 2'h0;
  localparam logic [1:0] BUS_16 = 2'h1;
  localparam logic [1:0] BUS_32 = 2'h2;
  localparam logic [1:0] BUS_64 = 2'h3;

  // Column counts
  localparam logic [3:0] NCB_MIN     = 4'h8;
  localparam logic [3:0] NCB_MAX     = 4'hA;
  localparam logic [3:0] NCB_EARLY16 = 4'h8;
  localparam logic [3:0] NCB_EARLY8  = 4'h9;

  // Row size codes and row pin counts
  localparam logic [1:0] ROW_SZ_11 = 2'h0;
  localparam logic [1:0] ROW_SZ_12 = 2'h1;
  localparam logic [1:0] ROW_SZ_13 = 2'h3;
  localparam logic [4:0] NRB_11    = 5'h0B;
  localparam logic [4:0] NRB_12    = 5'h0C;
  localparam logic [4:0] NRB_13    = 5'h0D;

  // Bank-select pin counts
  localparam logic [4:0] NBB_ONE = 5'h01;
  localparam logic [4:0] NBB_TWO = 5'h02;

endpackage
`default_nettype wire

//--- logic/sdram_row_col_address_mux.sv
/*
  SDRAM row/column address multiplexer for three controller generations.
  Assumes commands arrive as one-cycle pulses synchronous to clk, and that
  configuration inputs are stable around a command. Pins update one cycle
  after the command that selects them.
*/
// Functional notes
// - Earliest generation: shift set only by column width, 1 is x16, 0 is x8.
// - Earliest generation: dedicated precharge pin low during read and write.
// - Second generation: bus width and column size set the shift.
// - Bank bits latched at activate, repeated on pins during read and write.
// - Second generation: bank pins begin at 13, 14 or 15 by row size.
// - Bank span is one pin for bank size 0, two for 1.
// - Second generation: pin 12 acts as the A10 precharge input.
// - Second generation: pin 12 low during read and write.
// - Lowest pin: bit log2(bytes) on column, plus column count on row.
// - Second generation: row cycle drives exactly row plus bank pins; higher pins released.
// - Second generation: column cycle drives only slots 0 to 10 plus the bank bits.
// - Third generation: bus width and column size set the shift.
// - Third generation: pins above precharge latched at row, repeated at column.
// - Third generation: precharge pin 13 wide, 11 narrow, low on read/write.
// - Narrow port supports 8 and 16 bits only; wide adds 32 and 64.
// - Third generation: indicator pin 1 normal, 0 for peripheral transfers.
`timescale 1ns/1ps
`default_nettype none
module sdram_row_col_address_mux (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Configuration
  input  wire logic [1:0]  generation,
  input  wire logic        narrow_port_select,
  input  wire logic        column_width_select,
  input  wire logic [1:0]  column_size_field,
  input  wire logic [1:0]  row_size_field,
  input  wire logic        bank_size_field,
  input  wire logic [1:0]  bus_width_field,
  // Access request
  input  wire logic [31:0] byte_address,
  input  wire logic        peripheral_device_transfer,
  input  wire logic        activate_command,
  input  wire logic        read_command,
  input  wire logic        write_command,
  input  wire logic        deactivate_bank_command,
  // Memory pins
  output logic      [22:0] external_address_pins,
  output logic      [22:0] external_address_oe,
  output logic             dedicated_precharge_pin,
  output logic             dedicated_precharge_oe,
  // Status
  output logic      [1:0]  address_phase,
  output logic             config_error
);

  ////////////////////////////////////////////////////////////////////////////
  // Geometry decode

  logic [1:0]  lb;
  logic [3:0]  ncb;
  logic [4:0]  nrb;
  logic [4:0]  nbb;
  logic [1:0]  base;
  logic [3:0]  row_shift;
  logic [3:0]  col_shift;
  logic        width_bad;
  logic [15:0] row_slice;
  logic [15:0] col_slice;
  logic        is_early;
  logic        is_second;
  logic        is_third;

  assign is_early  = (generation == sdram_addr_pkg::GEN_EARLY);
  assign is_second = (generation == sdram_addr_pkg::GEN_SECOND);
  assign is_third  = (generation == sdram_addr_pkg::GEN_THIRD);

  always_comb begin
    width_bad = 1'b0;
    lb        = bus_width_field;
    base      = sdram_addr_pkg::BASE_EARLY;
    if (is_early) begin
      // Fixed 32-bit bus; column width alone picks the column count
      lb  = sdram_addr_pkg::BUS_32;
      ncb = column_width_select ? sdram_addr_pkg::NCB_EARLY16
                                : sdram_addr_pkg::NCB_EARLY8;
    end else begin
      // Column size alone sets the column count
      ncb = sdram_addr_pkg::NCB_MIN + {2'h0, column_size_field};
      if (ncb > sdram_addr_pkg::NCB_MAX) begin
        ncb = sdram_addr_pkg::NCB_MAX;
      end
    end
    if (is_second && bus_width_field == sdram_addr_pkg::BUS_64) begin
      width_bad = 1'b1;
      lb        = sdram_addr_pkg::BUS_32;
    end
    if (is_third) begin
      base = narrow_port_select ? sdram_addr_pkg::BASE_NARROW
                                : sdram_addr_pkg::BASE_WIDE;
      // Narrow port is clamped to 16 bits and flags the bad setting
      if (narrow_port_select && bus_width_field > sdram_addr_pkg::BUS_16) begin
        width_bad = 1'b1;
        lb        = sdram_addr_pkg::BUS_16;
      end
    end
    case (row_size_field)
      sdram_addr_pkg::ROW_SZ_12: nrb = sdram_addr_pkg::NRB_12;
      sdram_addr_pkg::ROW_SZ_13: nrb = sdram_addr_pkg::NRB_13;
      default:                   nrb = sdram_addr_pkg::NRB_11;
    endcase
    nbb       = bank_size_field ? sdram_addr_pkg::NBB_TWO : sdram_addr_pkg::NBB_ONE;
    row_shift = {2'h0, lb} + ncb;
    col_shift = {2'h0, lb};
  end

  addr_shift u_row_shift (
    .byte_address (byte_address),
    .shift        (row_shift),
    .slice        (row_slice)
  );

  addr_shift u_col_shift (
    .byte_address (byte_address),
    .shift        (col_shift),
    .slice        (col_slice)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Logical slot vectors, slot 0 is the lowest used pin

  logic [19:0] latch_q;
  logic [19:0] latch_d;
  logic [19:0] ras_vec;
  logic [19:0] ras_oe;
  logic [19:0] cas_vec;
  logic [19:0] cas_oe;

  always_comb begin
    ras_vec = {4'h0, row_slice};
    // Slot 10 left at zero in second and third generation column cycles: no autoprecharge
    cas_vec = 20'h00000;
    ras_oe  = 20'h00000;
    cas_oe  = 20'h00000;
    if (is_third) begin
      ras_vec[sdram_addr_pkg::K_INDICATOR] = ~peripheral_device_transfer;
    end
    for (int k = 0; k < sdram_addr_pkg::LOGICAL_W; k++) begin
      if (k < ncb) begin
        cas_vec[k] = col_slice[k];
      end else if (is_early || k > sdram_addr_pkg::K_PRECHARGE) begin
        // Repeat what the row cycle latched, bank bits included
        cas_vec[k] = latch_q[k];
      end
      if (is_early) begin
        // Slot 10 goes to the dedicated precharge pin instead
        ras_oe[k] = (k <= sdram_addr_pkg::K_EARLY_TOP) && (k != sdram_addr_pkg::K_PRECHARGE);
        cas_oe[k] = ras_oe[k];
      end else if (is_second) begin
        ras_oe[k] = (k < nrb + nbb);
        cas_oe[k] = (k <= sdram_addr_pkg::K_PRECHARGE)
                    || ((k >= nrb) && (k < nrb + nbb));
      end else begin
        // Slots above the indicator stay zero: driven low
        ras_oe[k] = 1'b1;
        cas_oe[k] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase and pin registers

  sdram_addr_pkg::phase_e phase_q;
  sdram_addr_pkg::phase_e phase_d;
  logic [22:0] pins_q;
  logic [22:0] pins_d;
  logic [22:0] oe_q;
  logic [22:0] oe_d;
  logic        prech_q;
  logic        prech_d;
  logic        prech_oe_q;
  logic        prech_oe_d;
  logic        cfg_err_q;
  logic        cfg_err_d;

  always_comb begin
    phase_d    = phase_q;
    pins_d     = pins_q;
    oe_d       = oe_q;
    prech_d    = prech_q;
    prech_oe_d = prech_oe_q;
    latch_d    = latch_q;
    cfg_err_d  = cfg_err_q;
    // Activate wins when several commands coincide
    if (activate_command) begin
      phase_d    = sdram_addr_pkg::PH_ROW;
      pins_d     = {3'h0, ras_vec} << base;
      oe_d       = {3'h0, ras_oe} << base;
      latch_d    = ras_vec;
      prech_d    = row_slice[sdram_addr_pkg::K_PRECHARGE];
      prech_oe_d = is_early;
      cfg_err_d  = width_bad;
    end else if (read_command || write_command) begin
      phase_d    = sdram_addr_pkg::PH_COL;
      pins_d     = {3'h0, cas_vec} << base;
      oe_d       = {3'h0, cas_oe} << base;
      prech_d    = 1'b0;
      prech_oe_d = is_early;
      cfg_err_d  = width_bad;
    end else if (deactivate_bank_command) begin
      // Pins keep their last value; only the phase is dropped
      phase_d = sdram_addr_pkg::PH_IDLE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q    <= sdram_addr_pkg::PH_IDLE;
      pins_q     <= 23'h000000;
      oe_q       <= 23'h000000;
      prech_q    <= 1'b0;
      prech_oe_q <= 1'b0;
      latch_q    <= 20'h00000;
      cfg_err_q  <= 1'b0;
    end else begin
      phase_q    <= phase_d;
      pins_q     <= pins_d;
      oe_q       <= oe_d;
      prech_q    <= prech_d;
      prech_oe_q <= prech_oe_d;
      latch_q    <= latch_d;
      cfg_err_q  <= cfg_err_d;
    end
  end

  assign external_address_pins   = pins_q;
  assign external_address_oe     = oe_q;
  assign dedicated_precharge_pin = prech_q;
  assign dedicated_precharge_oe  = prech_oe_q;
  assign address_phase           = phase_q;
  assign config_error            = cfg_err_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic rw;
  assign rw = (read_command || write_command) && !activate_command;

  early_width_a: assert property ((activate_command && is_early) |=>
    pins_q[2] == ($past(column_width_select) ? $past(byte_address[10])
                                             : $past(byte_address[11])))
    else $error("early row shift wrong");

  early_prech_a: assert property ((rw && is_early) |=>
    (!prech_q && prech_oe_q && !oe_q[12]))
    else $error("early precharge pin not low");

  second_shift_a: assert property ((rw && is_second && bus_width_field == 2'h1) |=>
    pins_q[2] == $past(byte_address[1]))
    else $error("second column shift wrong");

  bank_hold_a: assert property ((activate_command && is_second && row_size_field == 2'h0)
    ##1 (rw && is_second && row_size_field == 2'h0) |=> pins_q[13] == $past(pins_q[13]))
    else $error("bank bit not repeated");

  bank_start_a: assert property ((activate_command && is_second && row_size_field == 2'h1
    && !bank_size_field) |=> (oe_q[14] && !oe_q[15]))
    else $error("bank pin start wrong");

  bank_span_a: assert property ((activate_command && is_second && row_size_field == 2'h1
    && bank_size_field) |=> (oe_q[15] && !oe_q[16]))
    else $error("bank pin span wrong");

  second_prech_a: assert property ((rw && is_second) |=>
    (!pins_q[12] && oe_q[12] && !prech_oe_q))
    else $error("second precharge pin not low");

  row_lowbit_a: assert property ((activate_command && is_second && bus_width_field == 2'h2
    && column_size_field == 2'h1) |=> pins_q[2] == $past(byte_address[11]))
    else $error("row lowest bit wrong");

  row_count_a: assert property ((activate_command && is_second && row_size_field == 2'h0
    && !bank_size_field) |=> (oe_q[13] && !oe_q[14]))
    else $error("row pin count wrong");

  col_bank_a: assert property ((rw && is_second && row_size_field == 2'h3
    && bank_size_field) |=> (oe_q[16:15] == 2'h3 && oe_q[14:13] == 2'h0))
    else $error("column bank drive wrong");

  third_shift_a: assert property ((rw && is_third && !narrow_port_select
    && bus_width_field == 2'h3) |=> pins_q[3] == $past(byte_address[3]))
    else $error("third column shift wrong");

  third_repeat_a: assert property ((activate_command && is_third && !narrow_port_select)
    ##1 (rw && is_third && !narrow_port_select) |=> pins_q[18:14] == $past(pins_q[18:14]))
    else $error("upper bits not repeated");

  third_prech_a: assert property ((rw && is_third) |=>
    ($past(narrow_port_select) ? !pins_q[11] : !pins_q[13]))
    else $error("third precharge pin not low");

  narrow_width_a: assert property ((activate_command && is_third && narrow_port_select
    && bus_width_field == 2'h3) |=> config_error)
    else $error("narrow width not flagged");

  xfer_flag_a: assert property ((activate_command && is_third && !narrow_port_select) |=>
    pins_q[19] == !$past(peripheral_device_transfer))
    else $error("indicator pin wrong");

  upper_low_a: assert property (((activate_command || rw) && is_third && !narrow_port_select)
    |=> (pins_q[22:20] == 3'h0 && oe_q[22:20] == 3'h7))
    else $error("upper pins not low");

  early_cycle_c: cover property ((activate_command && is_early) ##1 (rw && is_early));
  second_cycle_c: cover property ((activate_command && is_second) ##1 (rw && is_second));
  third_wide_c: cover property ((activate_command && is_third && !narrow_port_select)
    ##[1:4] (rw && is_third));
  periph_access_c: cover property (activate_command && is_third && peripheral_device_transfer);

endmodule
`default_nettype wire

//--- sim/sdram_model.sv
/*
  Behavioural memory on the far side of the address pins.
  Assumes the multiplexer's pin, enable and phase outputs; one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sdram_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Pins from the controller
  input  wire logic [22:0] pins,
  input  wire logic [22:0] pins_oe,
  input  wire logic [1:0]  phase,
  // Addresses the memory latched
  output logic      [22:0] row_seen,
  output logic      [22:0] col_seen
);
  logic [22:0] last_q;
  logic [22:0] bus;

  // Released pins float: inverse of last level, so stale data never matches
  assign bus = (pins & pins_oe) | (~last_q & ~pins_oe);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_q   <= 23'h000000;
      row_seen <= 23'h000000;
      col_seen <= 23'h000000;
    end else begin
      last_q <= bus;
      if (phase == sdram_addr_pkg::PH_ROW) row_seen <= bus;
      if (phase == sdram_addr_pkg::PH_COL) col_seen <= bus;
    end
  end
endmodule
`default_nettype wire

//--- sim/tb.sv
/*
  Self-checking bench for the SDRAM row/column address multiplexer.
  Assumes sdram_model as the memory side and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [1:0]  generation = 2'h0;
  logic        narrow_port_select = 1'b0;
  logic        column_width_select = 1'b0;
  logic [1:0]  column_size_field = 2'h0;
  logic [1:0]  row_size_field = 2'h0;
  logic        bank_size_field = 1'b0;
  logic [1:0]  bus_width_field = 2'h0;
  logic [31:0] byte_address = 32'h0;
  logic        peripheral_device_transfer = 1'b0;
  logic        activate_command = 1'b0;
  logic        read_command = 1'b0;
  logic        write_command = 1'b0;
  logic        deactivate_bank_command = 1'b0;
  logic [22:0] apins, apins_oe, row_seen, col_seen;
  logic        pre, pre_oe, cfg_err;
  logic [1:0]  phase;
  logic [19:0] lat_q;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycles = 0;

  sdram_row_col_address_mux u_dut (
    .clk, .reset_n, .generation, .narrow_port_select, .column_width_select,
    .column_size_field, .row_size_field, .bank_size_field, .bus_width_field,
    .byte_address, .peripheral_device_transfer, .activate_command, .read_command,
    .write_command, .deactivate_bank_command,
    .external_address_pins(apins), .external_address_oe(apins_oe),
    .dedicated_precharge_pin(pre), .dedicated_precharge_oe(pre_oe),
    .address_phase(phase), .config_error(cfg_err)
  );
  sdram_model u_mem (.clk, .reset_n, .pins(apins), .pins_oe(apins_oe), .phase,
                     .row_seen, .col_seen);

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference image of the pins, worked out from the slot mapping
  function automatic void expect_img(input bit row, output logic [22:0] p,
                                     output logic [22:0] o, output logic pc, output logic err);
    int lb, ncb, nrb, nbb, base;
    bit early;
    logic [19:0] s, e;
    early = (generation == 2'h0);
    err = (generation == 2'h1 && bus_width_field == 2'h3) ||
          (generation == 2'h2 && narrow_port_select && bus_width_field > 2'h1);
    lb = int'(bus_width_field);
    if (early) lb = 2;
    if (err) lb = (generation == 2'h1) ? 2 : 1;
    ncb = early ? (column_width_select ? 8 : 9) :
          (column_size_field == 2'h3) ? 10 : 8 + int'(column_size_field);
    nrb = (row_size_field == 2'h1) ? 12 : (row_size_field == 2'h3) ? 13 : 11;
    nbb = bank_size_field ? 2 : 1;
    base = (generation == 2'h2) ? (narrow_port_select ? 1 : 3) : 2;
    p = 23'h0;
    o = 23'h0;
    for (int k = 0; k < 20; k++) begin
      if (row) s[k] = (k < 16) ? byte_address[lb+ncb+k] :
                      (k == 16 && generation == 2'h2) ? ~peripheral_device_transfer : 1'b0;
      else if (k < ncb) s[k] = byte_address[lb+k];
      else if ((k <= 10 && !early) || k == 10) s[k] = 1'b0;
      else s[k] = lat_q[k];
      if (early) e[k] = (k <= 14 && k != 10);
      else if (generation == 2'h1) e[k] = (!row && k <= 10) || (k < nrb + nbb && (row || k >= nrb));
      else e[k] = 1'b1;
      p[base+k] = s[k];
      o[base+k] = e[k];
    end
    pc = s[10];
    if (row) lat_q = s;
  endfunction

  task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Command pulse, then one edge for the pins and one for the memory to latch
  task automatic access(input int kind);
    logic [22:0] p, o;
    logic pc, err;
    @(posedge clk);
    activate_command <= (kind == 0);
    read_command <= (kind == 1);
    write_command <= (kind == 2);
    @(posedge clk);
    activate_command <= 1'b0;
    read_command <= 1'b0;
    write_command <= 1'b0;
    @(posedge clk);
    #1;
    expect_img(kind == 0, p, o, pc, err);
    chk("pin enables", o, apins_oe);
    chk("address seen", p & o, ((kind == 0) ? row_seen : col_seen) & o);
    chk("phase", (kind == 0) ? 23'h1 : 23'h2, {21'h0, phase});
    if (generation == 2'h0) chk("precharge pin", {22'h0, pc}, {22'h0, pre});
    chk("precharge enable", {22'h0, generation == 2'h0}, {22'h0, pre_oe});
    chk("config error", {22'h0, err}, {22'h0, cfg_err});
  endtask

  task automatic setup(input logic [1:0] g, input logic n, input logic [1:0] cs,
                       input logic [1:0] rs, input logic bs, input logic [1:0] bw,
                       input logic periph, input logic [31:0] a);
    @(posedge clk);
    generation <= g;
    narrow_port_select <= n;
    column_size_field <= cs;
    column_width_select <= cs[0];
    row_size_field <= rs;
    bank_size_field <= bs;
    bus_width_field <= bw;
    peripheral_device_transfer <= periph;
    byte_address <= a;
  endtask

  task automatic pair(input int i);
    access(0);
    access(i[0] ? 2 : 1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    #1;
    chk("reset pins", 23'h0, apins);
    chk("reset enables", 23'h0, apins_oe);
    chk("reset status", 23'h0, {18'h0, phase, pre, pre_oe, cfg_err});
    $display("test reset done");
  endtask

  task automatic t_early();
    for (int i = 0; i < 4; i++) begin
      setup(2'h0, 1'b0, 2'(i / 2), 2'h1, 1'b1, 2'h3, 1'b0, 32'h5A3C96E1 + 32'(i) * 32'h01234567);
      pair(i);
    end
    $display("test early done");
  endtask

  task automatic t_second();
    int i;
    i = 0;
    // All codes of each size and width field, the clamped ones included
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        for (int b = 0; b < 2; b++)
          for (int w = 0; w < 4; w++) begin
            setup(2'h1, 1'b0, 2'(c), 2'(r), b[0], 2'(w), 1'b0,
                  32'hE1D2C3B4 ^ (32'(i) * 32'h0F1E2D3B));
            pair(i);
            i++;
          end
    $display("test second done");
  endtask

  task automatic t_third();
    int i;
    i = 0;
    for (int n = 0; n < 2; n++)
      for (int w = 0; w < 4; w++)
        for (int c = 0; c < 3; c++)
          for (int d = 0; d < 2; d++) begin
            setup(2'h2, n[0], 2'(c), (c == 2) ? 2'h3 : 2'(c), d[0], 2'(w), d[0],
                  32'h96E15A3C ^ (32'(i) * 32'h13579BDF));
            pair(i);
            i++;
          end
    $display("test third done");
  endtask

  task automatic t_deact();
    logic [22:0] p, o, held;
    logic pc, err;
    for (int g = 0; g < 3; g++) begin
      // Second generation runs with 11 row pins so the bank repeat is exercised
      setup(2'(g), 1'b0, 2'h1, 2'(g / 2), 1'b1, 2'h2, 1'b1, 32'hC3A5F00F);
      @(posedge clk);
      activate_command <= 1'b1;
      @(posedge clk);
      activate_command <= 1'b0;
      read_command <= 1'b1;
      #1;
      expect_img(1'b1, p, o, pc, err);
      chk("back to back row", p & o, apins & o);
      @(posedge clk);
      read_command <= 1'b0;
      deactivate_bank_command <= 1'b1;
      #1;
      expect_img(1'b0, p, o, pc, err);
      chk("back to back column", p & o, apins & o);
      held = apins;
      @(posedge clk);
      deactivate_bank_command <= 1'b0;
      #1;
      chk("idle phase", 23'h0, {21'h0, phase});
      chk("pins held", held, apins);
    end
    $display("test deactivate done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_early();
    t_second();
    t_third();
    t_deact();
    give_verdict();
  end
endmodule
`default_nettype wire
